// [hw/emo_decode.v]
// Purpose: decode and hold extended operating mode one from the command pins
// Assumes: command pins already synchronous to core_clk via two flops here
// Notes: only this register is held; other selections are ignored
`timescale 1ns/100ps
`include "emo_map.vh"
module emo_decode
#(
  parameter WIDE8 = 1,
  parameter LOCK_CYC = `EMO_LOCK_CYC
)
(
  input wire core_clk,
  input wire resetn,
  input wire cs_n,
  input wire act_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] bg,
  input wire [1:0] ba,
  input wire [17:0] addr,
  input wire self_refresh,
  input wire loop_reset,
  input wire write_active,
  input wire term_ctl,
  input wire [2:0] write_termination,
  input wire [2:0] park_termination,
  output reg output_disable,
  output reg extra_termination_strobe,
  output reg [2:0] nominal_termination,
  output reg write_level_mode,
  output reg [2:0] receive_equalisation,
  output reg [1:0] extra_command_latency,
  output reg [1:0] driver_impedance_select,
  output reg loop_enable,
  output wire loop_running,
  output wire loop_locked,
  output wire write_term_unsafe,
  output reg [2:0] active_termination,
  output reg [1:0] termination_source,
  output reg bad_write
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [26:0] pin_s1_r; // first stage, read only by second
  reg [26:0] pin_s2_r; // second stage
  reg [1:0] misc_s1_r; // self refresh and loop reset
  reg [1:0] misc_s2_r; // second stage of the two levels
  wire [26:0] pin_raw; // five command pins over the 22-bit word
  // address pins 16..14 carry nothing here and read as zero
  assign pin_raw = {cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr[17], 3'h0, addr[13:0]};
  // two flops on every command pin and on both levels before decode
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // reset: pins read as deselected, levels low
      pin_s1_r <= {27{1'b1}};
      pin_s2_r <= {27{1'b1}};
      misc_s1_r <= 2'h0;
      misc_s2_r <= 2'h0;
    end
    else
    begin
      // sample every edge; decode reads stage two only
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      misc_s1_r <= {self_refresh, loop_reset};
      misc_s2_r <= misc_s1_r;
    end
  end
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire [21:0] word; // register word from pins
  wire is_mrs; // mode register set seen
  wire [2:0] sel; // target register select
  wire hit; // this register addressed
  wire sr_now; // synchronised self refresh
  wire lreset_now; // synchronised loop reset
  reg sr_d_r; // self refresh last cycle
  reg lreset_d_r; // loop reset last cycle
  // map pins onto word bits 21..0
  assign word = pin_s2_r[21:0];
  assign is_mrs = !pin_s2_r[26] && pin_s2_r[25] && !pin_s2_r[24]
    && !pin_s2_r[23] && !pin_s2_r[22];
  assign sel = word[`EMO_SEL_HI:`EMO_SEL_LO];
  assign hit = is_mrs && (sel == `EMO_SEL_THIS);
  assign sr_now = misc_s2_r[1];
  assign lreset_now = misc_s2_r[0];
  // reserved bits or reserved codes written
  function rsv_bad;
    input [21:0] w;
    begin
      rsv_bad = w[`EMO_RSV_HI_BIT] || w[`EMO_RSV_LO_BIT]
        || (w[`EMO_AL_HI:`EMO_AL_LO] == `EMO_AL_RSV)
        || w[`EMO_ODI_HI]
        || (w[`EMO_SEL_HI:`EMO_SEL_LO] == `EMO_SEL_DNU);
    end
  endfunction
  // ----------------------------------------
  // word helpers
  // ----------------------------------------
  // equalisation bits sit apart in the word; gather them once
  function [2:0] eq_field;
    input [21:0] w;
    begin
      eq_field = {w[`EMO_EQ_BIT2], w[`EMO_EQ_BIT1], w[`EMO_EQ_BIT0]};
    end
  endfunction
  // ----------------------------------------
  // output buffer controls
  // ----------------------------------------
  // fields load only on a hit and hold otherwise
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // power-up: buffers connected, no strobe termination
      output_disable <= 1'b0;
      extra_termination_strobe <= 1'b0;
    end
    else if (hit)
    begin
      // cut off drivers and termination together
      output_disable <= word[`EMO_QOFF_BIT];
      // strobe termination only exists in by-eight parts
      extra_termination_strobe <= word[`EMO_TSTRB_BIT] && (WIDE8 != 0);
    end
    else
    begin
      // no command for us: keep last written values
      output_disable <= output_disable;
      extra_termination_strobe <= extra_termination_strobe;
    end
  end
  // ----------------------------------------
  // termination and leveling fields
  // ----------------------------------------
  // nominal code is stored raw; the selector interprets it
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // power-up: nominal termination off, normal writes
      nominal_termination <= `EMO_TERM_OFF;
      write_level_mode <= 1'b0;
    end
    else if (hit)
    begin
      // all eight nominal codes are legal
      nominal_termination <= word[`EMO_NOM_HI:`EMO_NOM_LO];
      // leveling mode follows the bit directly
      write_level_mode <= word[`EMO_WLEV_BIT];
    end
    else
    begin
      // hold until this register is selected again
      nominal_termination <= nominal_termination;
      write_level_mode <= write_level_mode;
    end
  end
  // ----------------------------------------
  // latency, impedance and equalisation fields
  // ----------------------------------------
  // reserved codes are stored as written and flagged below
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // power-up: no extra latency, lowest impedance code
      receive_equalisation <= 3'h0;
      extra_command_latency <= 2'h0;
      driver_impedance_select <= 2'h0;
    end
    else if (hit)
    begin
      // equalisation has no function; held for its output only, the flag reads the word
      receive_equalisation <= eq_field(word);
      // latency code relative to the read latency setting
      extra_command_latency <= word[`EMO_AL_HI:`EMO_AL_LO];
      // only the two lowest codes name a driver strength
      driver_impedance_select <= word[`EMO_ODI_HI:`EMO_ODI_LO];
    end
    else
    begin
      // keep the last written codes
      receive_equalisation <= receive_equalisation;
      extra_command_latency <= extra_command_latency;
      driver_impedance_select <= driver_impedance_select;
    end
  end
  // ----------------------------------------
  // loop enable and reserved flag
  // ----------------------------------------
  // loop comes up enabled so the lock timer can run at once
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // power-up: loop on, nothing flagged
      loop_enable <= 1'b1;
      bad_write <= 1'b0;
    end
    else if (hit)
    begin
      // clearing the bit stops the loop and unlocks it
      loop_enable <= word[`EMO_DLL_BIT];
      // flag reserved settings; equalisation nonzero too
      bad_write <= rsv_bad(word) || (eq_field(word) != 3'h0);
    end
    else
    begin
      // flag stands until the next write to this register
      loop_enable <= loop_enable;
      bad_write <= bad_write;
    end
  end
  // ----------------------------------------
  // delay loop control
  // ----------------------------------------
  // loop runs when enabled and not in self refresh
  assign loop_running = loop_enable && !sr_now;
  wire lock_restart; // reset pulse or self refresh exit
  // edges on the second stage only
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // reset: idle levels, so no false edge follows
      sr_d_r <= 1'b0;
      lreset_d_r <= 1'b0;
    end
    else
    begin
      // delayed copies for edge detect
      sr_d_r <= sr_now;
      lreset_d_r <= lreset_now;
    end
  end
  assign lock_restart = (lreset_now && !lreset_d_r) || (sr_d_r && !sr_now);
  // lock countdown after each restart
  emo_lock_timer #(.LOCK_CYC(LOCK_CYC)) u_lock
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .loop_on(loop_running),
    .restart(lock_restart),
    .locked(loop_locked)
  );
  // write termination needs a locked loop
  assign write_term_unsafe = (write_termination != `EMO_TERM_OFF) && !loop_locked;
  // ----------------------------------------
  // termination choice
  // ----------------------------------------
  wire [1:0] src_c; // combinational source
  wire [2:0] code_c; // combinational code
  emo_term_sel u_term
  (
    .out_disable(output_disable),
    .write_active(write_active),
    .term_ctl(term_ctl),
    .nominal_code(nominal_termination),
    .write_code(write_termination),
    .park_code(park_termination),
    .term_source(src_c),
    .term_code(code_c)
  );
  // register the chosen termination
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // reset: no termination applied
      active_termination <= `EMO_TERM_OFF;
      termination_source <= 2'h0;
    end
    else
    begin
      // follow the selector one edge late
      active_termination <= code_c;
      termination_source <= src_c;
    end
  end
endmodule

// [hw/emo_map.vh]
// Purpose: constants for the extended operating mode one decoder
// Assumes: bit positions of the 22-bit mode register word
// Notes: included by every design file of the block
`ifndef EMO_MAP_VH
`define EMO_MAP_VH
// ----------------------------------------
// register word layout
// ----------------------------------------
`define EMO_WORD_W 22
`define EMO_SEL_HI 20
`define EMO_SEL_LO 18
`define EMO_SEL_THIS 3'h1
`define EMO_SEL_DNU 3'h7
`define EMO_RSV_HI_BIT 21
`define EMO_RSV_LO_BIT 17
`define EMO_EQ_BIT2 13
`define EMO_QOFF_BIT 12
`define EMO_TSTRB_BIT 11
`define EMO_NOM_HI 10
`define EMO_NOM_LO 8
`define EMO_WLEV_BIT 7
`define EMO_EQ_BIT1 6
`define EMO_EQ_BIT0 5
`define EMO_AL_HI 4
`define EMO_AL_LO 3
`define EMO_ODI_HI 2
`define EMO_ODI_LO 1
`define EMO_DLL_BIT 0
// ----------------------------------------
// reset values of the held fields
// ----------------------------------------
`define EMO_RST_WORD 22'h000001
// ----------------------------------------
// encodings
// ----------------------------------------
`define EMO_AL_RSV 2'h3
`define EMO_TERM_OFF 3'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define EMO_LOCK_CYC 768
`endif

// [hw/emo_term_sel.v]
// Purpose: choose the active termination code for the data pins
// Assumes: codes are raw field values; zero means no termination
// Notes: write termination beats nominal, park applies with control low
`timescale 1ns/100ps
`include "emo_map.vh"
module emo_term_sel
(
  input wire out_disable,
  input wire write_active,
  input wire term_ctl,
  input wire [2:0] nominal_code,
  input wire [2:0] write_code,
  input wire [2:0] park_code,
  output reg [1:0] term_source,
  output reg [2:0] term_code
);
  // ----------------------------------------
  // selection
  // ----------------------------------------
  // source: 0 none, 1 park, 2 nominal, 3 write
  always @*
  begin
    term_source = 2'h0;
    term_code = `EMO_TERM_OFF;
    if (out_disable)
    begin
      // buffers cut off: no termination at all
      term_source = 2'h0;
    end
    else if (!term_ctl)
    begin
      // park value whenever control pin low and outputs enabled
      term_source = 2'h1;
      term_code = park_code;
    end
    else if (write_active && (write_code != `EMO_TERM_OFF))
    begin
      // write value even with nominal off
      term_source = 2'h3;
      term_code = write_code;
    end
    else
    begin
      term_source = 2'h2;
      term_code = nominal_code;
    end
  end
endmodule

// [hw/emo_lock_timer.v]
// Purpose: count the loop lock interval after a loop reset
// Assumes: restart pulse comes from the same clock domain
// Notes: locked stays low while the loop is off
`timescale 1ns/100ps
`include "emo_map.vh"
module emo_lock_timer
#(
  parameter LOCK_CYC = `EMO_LOCK_CYC
)
(
  input wire core_clk,
  input wire resetn,
  input wire loop_on,
  input wire restart,
  output reg locked
);
  reg [15:0] count_r; // cycles left to lock
  // ----------------------------------------
  // countdown
  // ----------------------------------------
  // restart loads the full interval; loop off forces unlocked
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      // power-up waits one full interval like a restart
      count_r <= LOCK_CYC[15:0];
      locked <= 1'b0;
    end
    else if (!loop_on)
    begin
      count_r <= LOCK_CYC[15:0];
      locked <= 1'b0;
    end
    else if (restart)
    begin
      count_r <= LOCK_CYC[15:0];
      locked <= 1'b0;
    end
    else if (count_r != 16'h0000)
    begin
      count_r <= count_r - 16'h0001;
      locked <= 1'b0;
    end
    else
    begin
      locked <= 1'b1;
    end
  end
endmodule

// [tb/emo_dec_monitor.sv]
// Purpose: port timing checks for the mode register one decoder
// Assumes: fields land three edges after the command is sampled
// Notes: bound to every decoder instance
`timescale 1ns/100ps
module emo_dec_monitor
(
  input wire core_clk,
  input wire resetn,
  input wire cs_n,
  input wire act_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire self_refresh,
  input wire [1:0] bg,
  input wire [1:0] ba,
  input wire [17:0] addr,
  input wire write_active,
  input wire term_ctl,
  input wire output_disable,
  input wire loop_enable,
  input wire loop_running,
  input wire loop_locked,
  input wire write_term_unsafe,
  input wire bad_write,
  input wire write_level_mode,
  input wire [2:0] write_termination,
  input wire [2:0] park_termination,
  input wire [2:0] nominal_termination,
  input wire [2:0] active_termination,
  input wire [1:0] termination_source,
  input wire [1:0] extra_command_latency,
  input wire [1:0] driver_impedance_select
);
  // ----------------------------------------
  // command decode as seen on the pins
  // ----------------------------------------
  wire hit = !cs_n && act_n && !ras_n && !cas_n && !we_n && {bg[0], ba} == 3'h1;
  wire rsv = bg[1] | addr[17] | addr[13] | addr[6] | addr[5] | (addr[4] & addr[3]) | addr[2];
  wire [9:0] held = {output_disable, nominal_termination, extra_command_latency,
    driver_impedance_select, loop_enable, write_level_mode};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // field loading and holding
  // ----------------------------------------
  property p_qoff; hit |-> ##3 output_disable == $past(addr[12], 3); endproperty
  a_qoff: assert property (p_qoff) else $error("output disable not loaded");
  property p_nom; hit |-> ##3 nominal_termination == $past(addr[10:8], 3); endproperty
  a_nom: assert property (p_nom) else $error("nominal code not loaded");
  property p_lat;
    hit |-> ##3 {extra_command_latency, driver_impedance_select} == $past(addr[4:1], 3);
  endproperty
  a_lat: assert property (p_lat) else $error("latency or impedance not loaded");
  property p_mode;
    hit |-> ##3 {loop_enable, write_level_mode} == $past({addr[0], addr[7]}, 3);
  endproperty
  a_mode: assert property (p_mode) else $error("loop or leveling not loaded");
  property p_rsv; hit |-> ##3 bad_write == $past(rsv, 3); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  property p_hold; !hit |-> ##3 $stable(held); endproperty
  a_hold: assert property (p_hold) else $error("field moved without command");
  // ----------------------------------------
  // loop and termination
  // ----------------------------------------
  property p_sref; self_refresh [*3] |-> !loop_running; endproperty
  a_sref: assert property (p_sref) else $error("loop runs in self refresh");
  property p_unsafe;
    write_term_unsafe == (write_termination != 3'h0 && !loop_locked);
  endproperty
  a_unsafe: assert property (p_unsafe) else $error("unsafe flag wrong");
  property p_park;
    !term_ctl && !output_disable |=> termination_source == 2'h1
      && active_termination == $past(park_termination);
  endproperty
  a_park: assert property (p_park) else $error("park not applied");
  property p_wterm;
    term_ctl && write_active && write_termination != 3'h0 && !output_disable
      |=> termination_source == 2'h3;
  endproperty
  a_wterm: assert property (p_wterm) else $error("write termination not applied");
  property p_off; output_disable |=> termination_source == 2'h0; endproperty
  a_off: assert property (p_off) else $error("termination with outputs off");
endmodule
bind emo_decode emo_dec_monitor u_mon (.*);

// [tb/emo_ctl_model.sv]
// Purpose: controller model driving command and address pins
// Assumes: one command per call, pins change at the falling edge
// Notes: deselected lines other than act_n show the inverse of what they last carried
`timescale 1ns/100ps
module emo_ctl_model
(
  input wire core_clk,
  output reg cs_n,
  output reg act_n,
  output reg ras_n,
  output reg cas_n,
  output reg we_n,
  output reg [1:0] bg,
  output reg [1:0] ba,
  output reg [17:0] addr
);
  // idle: deselected
  initial
  begin
    {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
    {bg, ba, addr} = 22'h000000;
  end
  // one command cycle, then deselect with scrambled lines
  task issue(input [2:0] sel, input [21:0] w, input mrs);
  begin
    @(negedge core_clk);
    {cs_n, act_n} <= 2'h1;
    {ras_n, cas_n, we_n} <= {3{!mrs}};
    {bg, ba} <= {w[21], sel};
    addr <= {w[17], 3'h0, w[13:0]};
    @(negedge core_clk);
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n, bg, ba, addr} <= ~{ras_n, cas_n, we_n, bg, ba, addr};
  end
  endtask
endmodule

// [tb/tb.sv]
// Purpose: self-checking bench for the mode register one decoder
// Assumes: lock interval shortened to 8 cycles
// Notes: inputs change at the falling edge only
`timescale 1ns/100ps
module tb;
  reg core_clk = 1'b0;
  reg resetn = 1'b0;
  reg self_refresh = 1'b0;
  reg loop_reset = 1'b0;
  reg write_active = 1'b0;
  reg term_ctl = 1'b1;
  reg [2:0] write_termination = 3'h0;
  reg [2:0] park_termination = 3'h5;
  wire cs_n, act_n, ras_n, cas_n, we_n;
  wire [1:0] bg, ba;
  wire [17:0] addr;
  wire output_disable, extra_termination_strobe, write_level_mode, loop_enable;
  wire loop_running, loop_locked, write_term_unsafe, bad_write;
  wire [2:0] nominal_termination, receive_equalisation, active_termination;
  wire [1:0] extra_command_latency, driver_impedance_select, termination_source;
  integer miscompares = 0;
  integer tests_run = 0;
  integer cycles = 0;
  integer i;
  emo_ctl_model u_ctl (.*);
  emo_decode #(.LOCK_CYC(8)) uut (.*);
  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 2000)
    begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string name, input [21:0] exp, input [21:0] got);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      miscompares = miscompares + 1;
    end
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  // write this register and let the fields land
  task wr(input [21:0] w);
  begin
    u_ctl.issue(3'h1, w, 1'b1);
    cyc(2);
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    cyc(10);
    resetn = 1'b1;
    chk("reset", 22'h000001, {loop_locked, bad_write, active_termination, output_disable,
      extra_termination_strobe, nominal_termination, write_level_mode,
      extra_command_latency, driver_impedance_select, loop_enable});
    for (i = 0; i < 8; i = i + 1)
    begin
      wr({11'h000, i[2:0], 8'h01});
      chk("nominal", i[2:0], nominal_termination);
    end
    $display("test nominal done");
    for (i = 0; i < 4; i = i + 1)
    begin
      wr({17'h00000, i[1:0], i[1:0], 1'b1});
      chk("latency", i[1:0], extra_command_latency);
      chk("impedance", i[1:0], driver_impedance_select);
      chk("bad write", i > 1, bad_write);
    end
    $display("test latency done");
    wr(22'h001892);
    chk("modes", 4'hE, {output_disable, extra_termination_strobe, write_level_mode,
      loop_enable});
    u_ctl.issue(3'h0, 22'h000001, 1'b1);
    u_ctl.issue(3'h2, 22'h000001, 1'b1);
    u_ctl.issue(3'h7, 22'h000001, 1'b1);
    u_ctl.issue(3'h1, 22'h000001, 1'b0);
    cyc(2);
    chk("held", 6'h3A, {output_disable, extra_termination_strobe, write_level_mode,
      loop_enable, extra_command_latency});
    $display("test hold done");
    for (i = 0; i < 5; i = i + 1)
    begin
      wr((22'h000001 << ((i == 0) ? 21 : (i == 1) ? 17 : (i == 2) ? 13
        : (i == 3) ? 6 : 5)) | 22'h000001);
      chk("reserved", 1'b1, bad_write);
    end
    chk("equalisation", 3'h1, receive_equalisation);
    wr(22'h000001);
    chk("clean", 1'b0, bad_write);
    $display("test reserved done");
    write_active = 1'b1;
    write_termination = 3'h2;
    cyc(2);
    chk("write term", 5'h1A, {termination_source, active_termination});
    // loop locked long before: write termination is safe here
    chk("unsafe", 1'b0, write_term_unsafe);
    term_ctl = 1'b0;
    cyc(2);
    chk("park", 5'h0D, {termination_source, active_termination});
    term_ctl = 1'b1;
    write_active = 1'b0;
    wr(22'h000301);
    // termination registers one edge after the field lands
    cyc(1);
    chk("nominal term", 5'h13, {termination_source, active_termination});
    wr(22'h001301);
    cyc(1);
    chk("outputs off", 2'h0, termination_source);
    $display("test termination done");
    loop_reset = 1'b1;
    cyc(1);
    loop_reset = 1'b0;
    cyc(4);
    chk("lock pending", 2'h1, {loop_locked, write_term_unsafe});
    cyc(10);
    chk("locked", 2'h2, {loop_locked, write_term_unsafe});
    write_termination = 3'h0;
    wr(22'h000001);
    self_refresh = 1'b1;
    cyc(4);
    chk("self refresh", 2'h0, {loop_running, loop_locked});
    self_refresh = 1'b0;
    cyc(4);
    chk("exit", 1'b1, loop_running);
    cyc(10);
    chk("relock", 1'b1, loop_locked);
    $display("test loop done");
    wrap_up;
  end
endmodule
